// [resistor_serial_ctrl.sv]
/*
  Serial control logic of a dual variable resistor with nonvolatile backup.
  Samples the serial clock, select and data pins with REF_CLK, executes the
  word when select rises, drives the open-drain data out and ready outputs.
  Assumes the serial clock runs well below REF_CLK / 4.
*/
// Contract
// [R1] Capture one input bit per serial rising edge.
// [R2] Words travel most significant bit first.
// [R3] Word: four command, four address, sixteen data.
// [R4] Read commands drive readback on data out.
// [R5] Other commands forward previous word for chaining.
// [R6] Select active low; execute on select rising.
// [R7] Release data out while select is high.
// [R8] Write protect low blocks scratchpad changes.
// [R9] Restore commands work despite write protect.
// [R10] Preset reloads scratchpad on rising edge.
// [R11] Preset low holds wipers at midscale.
// [R12] Store defaults to midscale until written.
// [R13] Ready high marks completion of slow operations.
// [R14] Address zero selects first channel.
// [R15] Address one selects second channel.
// [R16] Store in progress locks the shift register.
// [R17] Host waits for ready before next word.
module resistor_serial_ctrl #(
  parameter int STORE_CYCLES   = resistor_ctrl_pkg::STORE_CYC,
  parameter int READ_CYCLES    = resistor_ctrl_pkg::READ_CYC,
  parameter int RESTORE_CYCLES = resistor_ctrl_pkg::RESTORE_CYC,
  parameter int PRESET_CYCLES  = resistor_ctrl_pkg::PRESET_CYC
) (
  // Clock, reset, enable.
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  // Serial link pins.
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SDI,
  output logic             SDO_O,
  output logic             SDO_OE,
  // Control pins.
  input  wire logic        WRITE_PROTECT_N,
  input  wire logic        PRESET_RELOAD_N,
  output logic             RDY_O,
  output logic             RDY_OE,
  // Wiper settings.
  output logic [9:0]       WIPER0,
  output logic [9:0]       WIPER1
);

  localparam int CW = 24;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic       sclk_prev_q;
  logic       cs_prev_q;
  logic       pr_prev_q;

  // Two flops on every pin before any logic reads it.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      // The serial clock idles low between frames; resetting its copies
      // low keeps a false fall from appearing right after reset.
      meta_q      <= 4'h7;
      sync_q      <= 4'h7;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
      pr_prev_q   <= 1'b1;
    end else if (CE) begin
      meta_q      <= {SCLK, CS_N, SDI, PRESET_RELOAD_N};
      sync_q      <= meta_q;
      sclk_prev_q <= sync_q[3];
      cs_prev_q   <= sync_q[2];
      pr_prev_q   <= sync_q[0];
    end
  end

  wire sclk_s  = sync_q[3];
  wire cs_n_s  = sync_q[2];
  wire sdi_s   = sync_q[1];
  wire pr_n_s  = sync_q[0];
  wire sclk_rise = sclk_s && !sclk_prev_q;
  wire sclk_fall = !sclk_s && sclk_prev_q;
  wire cs_rise   = cs_n_s && !cs_prev_q;
  wire pr_rise   = pr_n_s && !pr_prev_q;
  // Write protect is a slow level; one sampled copy is enough after sync.
  logic wp_meta_q;
  logic wp_n_q;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      wp_meta_q <= 1'b1;
      wp_n_q    <= 1'b1;
    end else if (CE) begin
      wp_meta_q <= WRITE_PROTECT_N;
      wp_n_q    <= wp_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Shift register and output stage
  // ----------------------------------------------------------------------
  logic [23:0] shift_q;
  logic        sdo_q;
  logic        busy;
  logic        store_busy_q;

  // Shift register is locked while a store runs, so a word sent too early
  // is dropped rather than corrupting the store. [R16]
  wire shift_en = !cs_n_s && sclk_rise && !store_busy_q;
  wire [23:0] shift_d = {shift_q[22:0], sdi_s};   // [R1] [R2]

  // Execute stage loads shift_q with readback; define here.
  logic        load_read;
  logic [23:0] read_word;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      shift_q <= 24'h00_0000;
    end else if (CE) begin
      if (load_read) begin
        shift_q <= read_word;                     // [R4]
      end else if (shift_en) begin
        shift_q <= shift_d;                       // [R1] [R5]
      end
    end
  end

  // Data out changes on the falling serial edge and presents the top bit,
  // so a word shifted in appears on the next frame for chaining. [R5]
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      sdo_q <= 1'b1;
    end else if (CE) begin
      if (cs_n_s) begin
        sdo_q <= 1'b1;
      end else if (sclk_fall || (cs_prev_q && !cs_n_s)) begin
        sdo_q <= shift_q[23];                     // [R2]
      end
    end
  end

  assign SDO_O  = 1'b0;
  // Open drain: only a low bit is driven; released under high select. [R7]
  assign SDO_OE = !cs_n_s && !sdo_q;

  // ----------------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------------
  wire [3:0]  cmd  = shift_q[resistor_ctrl_pkg::CMD_MSB:
                             resistor_ctrl_pkg::CMD_LSB];     // [R3]
  wire [3:0]  addr = shift_q[resistor_ctrl_pkg::ADDR_MSB:
                             resistor_ctrl_pkg::ADDR_LSB];
  wire [15:0] data = shift_q[resistor_ctrl_pkg::DATA_MSB:
                             resistor_ctrl_pkg::DATA_LSB];
  wire        ch   = addr[0];                     // [R14] [R15]
  wire        is_wiper = (addr == resistor_ctrl_pkg::ADDR_CH0) ||
                         (addr == resistor_ctrl_pkg::ADDR_CH1);
  // Execute only when select returns high. [R6]
  wire        exec = cs_rise && !busy;
  wire        wr_ok = wp_n_q;                     // [R8]

  // Saturating wiper arithmetic used by step and 6 dB commands.
  function automatic logic [9:0] wiper_adj(input logic [9:0] w,
                                           input logic [1:0] op);
    logic [10:0] t;
    t = {1'b0, w};
    unique case (op)
      2'd0: t = (w == 10'h000) ? 11'h000 : t - 11'h001;
      2'd1: t = (w == 10'h3FF) ? 11'h3FF : t + 11'h001;
      2'd2: t = {2'b00, w[9:1]};
      2'd3: t = (w[9]) ? 11'h3FF : {w, 1'b0};
    endcase
    return t[9:0];
  endfunction

  // Operation code: 0 step down, 1 step up, 2 halve, 3 double.
  wire [1:0] adj_op = (cmd == resistor_ctrl_pkg::CMD_DEC_STEP ||
                       cmd == resistor_ctrl_pkg::CMD_DEC_ALL) ? 2'd0 :
                      (cmd == resistor_ctrl_pkg::CMD_INC_STEP ||
                       cmd == resistor_ctrl_pkg::CMD_INC_ALL) ? 2'd1 :
                      (cmd == resistor_ctrl_pkg::CMD_DEC_6DB ||
                       cmd == resistor_ctrl_pkg::CMD_DEC_6DB_ALL) ? 2'd2 :
                      2'd3;
  wire is_adj_one = cmd == resistor_ctrl_pkg::CMD_DEC_6DB ||
                    cmd == resistor_ctrl_pkg::CMD_DEC_STEP ||
                    cmd == resistor_ctrl_pkg::CMD_INC_6DB ||
                    cmd == resistor_ctrl_pkg::CMD_INC_STEP;
  wire is_adj_all = cmd == resistor_ctrl_pkg::CMD_DEC_6DB_ALL ||
                    cmd == resistor_ctrl_pkg::CMD_DEC_ALL ||
                    cmd == resistor_ctrl_pkg::CMD_INC_6DB_ALL ||
                    cmd == resistor_ctrl_pkg::CMD_INC_ALL;

  // ----------------------------------------------------------------------
  // Scratchpad and nonvolatile store
  // ----------------------------------------------------------------------
  logic [9:0]  wiper_scratchpad_q [2];
  logic [15:0] nonvolatile_store_q [16];
  logic        store_pend_q;
  logic [3:0]  store_addr_q;
  logic [15:0] store_data_q;

  // Readback echoes command and address in the top byte, value below.
  wire [9:0] wip_sel = wiper_scratchpad_q[ch];
  assign load_read = exec && (cmd == resistor_ctrl_pkg::CMD_READ_STORE ||
                              cmd == resistor_ctrl_pkg::CMD_READ_WIPER);
  assign read_word = (cmd == resistor_ctrl_pkg::CMD_READ_STORE) ?
                     {cmd, addr, nonvolatile_store_q[addr]} :
                     {cmd, addr, 6'b00_0000, wip_sel};        // [R4]

  // Timer for the slow operations behind ready.
  logic          t_start;
  logic [CW-1:0] t_cycles;
  logic          t_done;

  wire is_store = cmd == resistor_ctrl_pkg::CMD_STORE ||
                  cmd == resistor_ctrl_pkg::CMD_STORE_ANY;
  wire is_slow  = is_store || load_read ||
                  cmd == resistor_ctrl_pkg::CMD_RESTORE_ALL;
  assign t_start  = (exec && is_slow) || pr_rise;
  assign t_cycles = pr_rise ? CW'(PRESET_CYCLES) :
                    is_store ? CW'(STORE_CYCLES) :
                    (cmd == resistor_ctrl_pkg::CMD_RESTORE_ALL) ?
                    CW'(RESTORE_CYCLES) : CW'(READ_CYCLES);

  // One timer serves every slow operation. A word whose select rises while
  // it runs is dropped, so the host must watch ready first.
  busy_timer #(.CW(CW)) u_timer (
    .clk    (REF_CLK),
    .rst_n  (RSTN),
    .ce     (CE),
    .start  (t_start),
    .cycles (t_cycles),
    .busy   (busy),
    .done   (t_done)
  );

  // Nonvolatile store: midscale for the wipers until written. [R12]
  // A preset rise during a store restarts the shared timer, so the store
  // then commits on the preset count instead of the store count.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < 16; i++) begin
        nonvolatile_store_q[i] <= resistor_ctrl_pkg::MIDSCALE;
      end
      store_busy_q <= 1'b0;
      store_addr_q <= 4'h0;
      store_data_q <= 16'h0000;
    end else if (CE) begin
      if (exec && is_store) begin
        store_busy_q <= 1'b1;                     // [R16]
        store_addr_q <= addr;
        store_data_q <= (cmd == resistor_ctrl_pkg::CMD_STORE_ANY &&
                         !is_wiper) ? data : {6'b00_0000, wip_sel};
      end else if (store_busy_q && t_done) begin
        store_busy_q <= 1'b0;
        nonvolatile_store_q[store_addr_q] <= store_data_q;
      end
    end
  end

  // Scratchpad updates; restores ignore write protect, writes honour it.
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      wiper_scratchpad_q[0] <= resistor_ctrl_pkg::MIDSCALE[9:0];
      wiper_scratchpad_q[1] <= resistor_ctrl_pkg::MIDSCALE[9:0];
    end else if (CE) begin
      if (!pr_n_s) begin
        wiper_scratchpad_q[0] <= resistor_ctrl_pkg::MIDSCALE[9:0]; // [R11]
        wiper_scratchpad_q[1] <= resistor_ctrl_pkg::MIDSCALE[9:0];
      end else if (pr_rise) begin
        wiper_scratchpad_q[0] <= nonvolatile_store_q[0][9:0];     // [R10]
        wiper_scratchpad_q[1] <= nonvolatile_store_q[1][9:0];
      end else if (exec && cmd == resistor_ctrl_pkg::CMD_RESTORE_ALL) begin
        wiper_scratchpad_q[0] <= nonvolatile_store_q[0][9:0];     // [R9]
        wiper_scratchpad_q[1] <= nonvolatile_store_q[1][9:0];
      end else if (exec && cmd == resistor_ctrl_pkg::CMD_RESTORE &&
                   is_wiper) begin
        wiper_scratchpad_q[ch] <= nonvolatile_store_q[addr][9:0]; // [R9]
      end else if (exec && wr_ok && is_wiper &&
                   cmd == resistor_ctrl_pkg::CMD_WRITE) begin
        wiper_scratchpad_q[ch] <= data[9:0];                      // [R8]
      end else if (exec && wr_ok && is_wiper && is_adj_one) begin
        wiper_scratchpad_q[ch] <= wiper_adj(wip_sel, adj_op);     // [R8]
      end else if (exec && wr_ok && is_adj_all) begin
        wiper_scratchpad_q[0] <= wiper_adj(wiper_scratchpad_q[0], adj_op);
        wiper_scratchpad_q[1] <= wiper_adj(wiper_scratchpad_q[1], adj_op);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Ready is low while a slow operation runs and released when it ends;
  // the host polls it before the next frame. [R13] [R17]
  assign RDY_O  = 1'b0;
  assign RDY_OE = busy;                            // [R13]
  assign WIPER0 = wiper_scratchpad_q[0];
  assign WIPER1 = wiper_scratchpad_q[1];

endmodule

// [resistor_ctrl_pkg.sv]
/*
  Shared constants for the dual resistor serial control logic: word layout,
  command codes, wiper codes and operation times.
  Assumes a 100 MHz system clock (REF_CLK) sampling the serial pins.
*/
package resistor_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int CMD_MSB   = 23;
  localparam int CMD_LSB   = 20;
  localparam int ADDR_MSB  = 19;
  localparam int ADDR_LSB  = 16;
  localparam int DATA_MSB  = 15;
  localparam int DATA_LSB  = 0;
  localparam int WIPER_BITS = 10;

  // ----------------------------------------------------------------------
  // Commands and addresses
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_NOP         = 4'h0;
  localparam logic [3:0] CMD_RESTORE     = 4'h1;
  localparam logic [3:0] CMD_STORE       = 4'h2;
  localparam logic [3:0] CMD_STORE_ANY   = 4'h3;
  localparam logic [3:0] CMD_DEC_6DB     = 4'h4;
  localparam logic [3:0] CMD_DEC_6DB_ALL = 4'h5;
  localparam logic [3:0] CMD_DEC_STEP    = 4'h6;
  localparam logic [3:0] CMD_DEC_ALL     = 4'h7;
  localparam logic [3:0] CMD_RESTORE_ALL = 4'h8;
  localparam logic [3:0] CMD_READ_STORE  = 4'h9;
  localparam logic [3:0] CMD_READ_WIPER  = 4'hA;
  localparam logic [3:0] CMD_WRITE       = 4'hB;
  localparam logic [3:0] CMD_INC_6DB     = 4'hC;
  localparam logic [3:0] CMD_INC_6DB_ALL = 4'hD;
  localparam logic [3:0] CMD_INC_STEP    = 4'hE;
  localparam logic [3:0] CMD_INC_ALL     = 4'hF;
  localparam logic [3:0] ADDR_CH0        = 4'h0;
  localparam logic [3:0] ADDR_CH1        = 4'h1;

  // ----------------------------------------------------------------------
  // Reset value and wiper maximum
  // ----------------------------------------------------------------------
  localparam logic [15:0] MIDSCALE = 16'h0200;
  localparam logic [15:0] WIPER_MAX = 16'h03FF;

  // ----------------------------------------------------------------------
  // Operation times and cycle counts at 100 MHz
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int STORE_US     = 15000;
  localparam int READ_US      = 7;
  localparam int RESTORE_US   = 20;
  localparam int PRESET_US    = 30;
  localparam int STORE_CYC    = STORE_US * CLK_MHZ;
  localparam int READ_CYC     = READ_US * CLK_MHZ;
  localparam int RESTORE_CYC  = RESTORE_US * CLK_MHZ;
  localparam int PRESET_CYC   = PRESET_US * CLK_MHZ;

endpackage

// [busy_timer.sv]
/*
  Down counter that holds busy for a loaded number of cycles.
  Assumes the caller pulses start only when a slow operation begins.
*/
module busy_timer #(
  parameter int CW = 24
) (
  // Clock, reset, enable.
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Start with a cycle count.
  input  wire logic          start,
  input  wire logic [CW-1:0] cycles,
  // Status.
  output logic               busy,
  output logic               done
);

  logic [CW-1:0] cnt_q;

  // Count down to zero; done pulses on the last cycle of the wait.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= cycles;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  assign busy = (cnt_q != '0);
  assign done = ce && !start && (cnt_q == CW'(1));

endmodule

// [resistor_serial_ctrl_chk.sv]
/*
  Checker for the serial control block, bound to its top ports.
  Assumes one clock domain with a synchronous active low reset.
*/
module resistor_serial_ctrl_chk #(
  parameter int STORE_CYCLES = 1500000
) (
  // Clock, reset, enable.
  input wire logic       REF_CLK,
  input wire logic       RSTN,
  input wire logic       CE,
  // Serial link pins.
  input wire logic       SCLK,
  input wire logic       CS_N,
  input wire logic       SDI,
  input wire logic       SDO_O,
  input wire logic       SDO_OE,
  // Control pins.
  input wire logic       WRITE_PROTECT_N,
  input wire logic       PRESET_RELOAD_N,
  input wire logic       RDY_O,
  input wire logic       RDY_OE,
  // Wiper settings.
  input wire logic [9:0] WIPER0,
  input wire logic [9:0] WIPER1
);
  // ------
  // Helpers
  // ------
  int   busy_q;
  int   age_q;
  logic cs_q;
  logic pr_q;
  wire logic cs_rise = CS_N & ~cs_q;
  wire logic pr_rise = PRESET_RELOAD_N & ~pr_q;

  // Busy length, and age of the last select or preset rise; the age
  // saturates so a long idle spell cannot wrap it.
  always_ff @(posedge REF_CLK) begin
    cs_q <= CS_N;
    pr_q <= PRESET_RELOAD_N;
    busy_q <= RDY_OE ? busy_q + 1 : 0;
    if (!RSTN) age_q <= 64;
    else if (cs_rise || pr_rise) age_q <= 0;
    else if (age_q < 64) age_q <= age_q + 1;
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence preset_held;
    !PRESET_RELOAD_N [*5];
  endsequence
  sequence frame_open;
    (!CS_N && PRESET_RELOAD_N) [*6];
  endsequence

  a_sdo_open_drain: assert property (SDO_O == 1'b0)
    else $error("data out drives high");
  a_rdy_open_drain: assert property (RDY_O == 1'b0)
    else $error("ready drives high");
  a_sdo_released: assert property (CS_N [*4] |-> !SDO_OE)
    else $error("data out held while deselected");
  a_rdy_min_span: assert property ($rose(RDY_OE) |-> RDY_OE [*8])
    else $error("busy pulse too short");
  a_rdy_max_span: assert property (busy_q <= STORE_CYCLES + 2)
    else $error("busy never ends");
  a_rdy_has_cause: assert property ($rose(RDY_OE) |-> age_q <= 8)
    else $error("busy without select or preset rise");
  a_preset_mid: assert property (preset_held |->
    WIPER0 == resistor_ctrl_pkg::MIDSCALE[9:0] &&
    WIPER1 == resistor_ctrl_pkg::MIDSCALE[9:0])
    else $error("wipers not midscale in preset");
  a_frame_no_exec: assert property (frame_open |->
    $stable(WIPER0) && $stable(WIPER1))
    else $error("wiper changed inside a frame");
endmodule

bind resistor_serial_ctrl resistor_serial_ctrl_chk #(
  .STORE_CYCLES(STORE_CYCLES)
) u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .CE(CE), .SCLK(SCLK),
  .CS_N(CS_N), .SDI(SDI), .SDO_O(SDO_O), .SDO_OE(SDO_OE),
  .WRITE_PROTECT_N(WRITE_PROTECT_N), .PRESET_RELOAD_N(PRESET_RELOAD_N),
  .RDY_O(RDY_O), .RDY_OE(RDY_OE), .WIPER0(WIPER0), .WIPER1(WIPER1));

// [host_spi_master.sv]
/*
  Host serial master model: select, clock and data toward the block.
  Assumes pulled-up data return and ready lines.
*/
module host_spi_master (
  // Bench clock.
  input wire logic clk,
  // Returned lines.
  input wire logic sdo,
  input wire logic rdy,
  // Serial pins.
  output logic     sclk,
  output logic     cs_n,
  output logic     sdi
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle: deselected, clock low.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // One 24 bit frame, top bit first, 160 ns clock.
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    int i;
    @(negedge clk);
    cs_n = 1'b0;
    for (i = 23; i >= 0; i--) begin
      sdi = w[i];
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      r[i] = sdo;
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
    // Released data is inverted so a stale value cannot pass.
    sdi = ~sdi;
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // Hold off the next frame until ready returns.
  task automatic wait_ready(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 5000 && !ok; n++) begin
      @(negedge clk);
      ok = (rdy === 1'b1);
    end
  endtask
endmodule

// [tb_dual_resistor_serial_control.sv]
/*
  Bench: a host model sends frames while the bench drives protect and
  preset and judges wipers, ready and readback.
  Assumes shortened slow-operation counts to keep the run brief.
*/
module tb_dual_resistor_serial_control;
  timeunit 1ns;
  timeprecision 1ns;

  // ------
  // Signals
  // ------
  localparam logic [23:0] MID = {8'h00, resistor_ctrl_pkg::MIDSCALE};
  logic        ref_clk;
  logic        rstn;
  logic        wp_n;
  logic        pr_n;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo_oe;
  logic        rdy_oe;
  logic [9:0]  w0;
  logic [9:0]  w1;
  logic [23:0] rx;
  bit          ok;
  int          err_total = 0;
  int          n_checks = 0;
  // Pull-ups on both open-drain lines.
  wire logic   sdo_line = ~sdo_oe;
  wire logic   rdy_line = ~rdy_oe;

  // Store stays longer than one frame so a frame can land inside it.
  resistor_serial_ctrl #(
    .STORE_CYCLES(1000), .READ_CYCLES(50),
    .RESTORE_CYCLES(50), .PRESET_CYCLES(50)
  ) DUT (
    .REF_CLK(ref_clk), .RSTN(rstn), .CE(1'b1), .SCLK(sclk),
    .CS_N(cs_n), .SDI(sdi), .SDO_O(), .SDO_OE(sdo_oe),
    .WRITE_PROTECT_N(wp_n), .PRESET_RELOAD_N(pr_n), .RDY_O(),
    .RDY_OE(rdy_oe), .WIPER0(w0), .WIPER1(w1)
  );
  host_spi_master host (.clk(ref_clk), .sdo(sdo_line), .rdy(rdy_line),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  task automatic cmp(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset();
    cmp("wiper0", MID, {14'h0, w0});
    cmp("wiper1", MID, {14'h0, w1});
    cmp("oe", 24'h0, {22'h0, sdo_oe, rdy_oe});
  endtask

  task automatic t_write();
    host.xfer(24'hB0_0100, rx);
    cmp("wiper0", 24'h0100, {14'h0, w0});
    host.xfer(24'hB1_0155, rx);
    cmp("wiper1", 24'h0155, {14'h0, w1});
    cmp("chain", 24'hB0_0100, rx);
  endtask

  task automatic t_read();
    host.xfer(24'hA0_0000, rx);
    cmp("busy", 24'h0, {23'h0, rdy_line});
    host.wait_ready(ok);
    cmp("ready", 24'h1, {23'h0, ok});
    host.xfer(24'h91_0000, rx);
    cmp("readback", 24'hA0_0100, rx);
    host.wait_ready(ok);
    host.xfer(24'h00_0000, rx);
    cmp("readback", 24'h91_0200, rx);
  endtask

  task automatic t_protect();
    wp_n = 1'b0;
    host.xfer(24'hB0_03FF, rx);
    cmp("wiper0", 24'h0100, {14'h0, w0});
    host.xfer(24'h10_0000, rx);
    repeat (100) @(negedge ref_clk);
    cmp("wiper0", MID, {14'h0, w0});
    host.xfer(24'h80_0000, rx);
    host.wait_ready(ok);
    cmp("wiper1", MID, {14'h0, w1});
    wp_n = 1'b1;
  endtask

  task automatic t_store();
    host.xfer(24'hB0_0123, rx);
    host.xfer(24'h20_0000, rx);
    host.xfer(24'hB0_03FF, rx);
    host.wait_ready(ok);
    cmp("wiper0", 24'h0123, {14'h0, w0});
    host.xfer(24'hB0_0000, rx);
    pr_n = 1'b0;
    repeat (20) @(negedge ref_clk);
    cmp("wiper0", MID, {14'h0, w0});
    pr_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    cmp("busy", 24'h0, {23'h0, rdy_line});
    host.wait_ready(ok);
    cmp("wiper0", 24'h0123, {14'h0, w0});
    cmp("wiper1", MID, {14'h0, w1});
  endtask

  task automatic t_adjust();
    host.xfer(24'hB0_0100, rx);
    host.xfer(24'hE0_0000, rx);
    cmp("wipers", {4'h0, 10'h200, 10'h101}, {4'h0, w1, w0});
    host.xfer(24'h40_0000, rx);
    cmp("wipers", {4'h0, 10'h200, 10'h080}, {4'h0, w1, w0});
    host.xfer(24'hD0_0000, rx);
    cmp("wipers", {4'h0, 10'h3FF, 10'h100}, {4'h0, w1, w0});
    host.xfer(24'h70_0000, rx);
    cmp("wipers", {4'h0, 10'h3FE, 10'h0FF}, {4'h0, w1, w0});
    host.xfer(24'h50_0000, rx);
    cmp("wipers", {4'h0, 10'h1FF, 10'h07F}, {4'h0, w1, w0});
    host.xfer(24'hF0_0000, rx);
    cmp("wipers", {4'h0, 10'h200, 10'h080}, {4'h0, w1, w0});
    host.xfer(24'hC1_0000, rx);
    cmp("wipers", {4'h0, 10'h3FF, 10'h080}, {4'h0, w1, w0});
    host.xfer(24'h61_0000, rx);
    cmp("wipers", {4'h0, 10'h3FE, 10'h080}, {4'h0, w1, w0});
  endtask

  task automatic t_store_any();
    host.xfer(24'h35_BEEF, rx);
    host.wait_ready(ok);
    cmp("ready", 24'h1, {23'h0, ok});
    host.xfer(24'h95_0000, rx);
    host.wait_ready(ok);
    host.xfer(24'h00_0000, rx);
    cmp("readback", 24'h95_BEEF, rx);
  endtask

  // Clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Watchdog, well beyond the roughly 11600 cycles the tests need.
  initial begin
    repeat (50000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end

  // Main sequence.
  initial begin
    rstn = 1'b0;
    wp_n = 1'b1;
    pr_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_write();
    t_read();
    t_protect();
    t_store();
    t_adjust();
    t_store_any();
    finish_test();
  end
endmodule
